// file: verilog/ast_defs.svh
// register offsets, field positions, reset values and timing for the sequencer
`ifndef AST_DEFS_SVH
`define AST_DEFS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define AST_OFF_CTRL 8'h00
`define AST_OFF_ARM_SRC 8'h04
`define AST_OFF_SCAN_SRC 8'h08
`define AST_OFF_ARM_CNT 8'h0C
`define AST_OFF_SCAN_CNT 8'h10
`define AST_OFF_TIMER 8'h14
`define AST_OFF_DELAY 8'h18
`define AST_OFF_CMD 8'h1C
`define AST_OFF_STATUS 8'h20
`define AST_OFF_PROG 8'h24

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define AST_CTRL_CONT 0
`define AST_CTRL_BYP 1
`define AST_CMD_INIT 0
`define AST_CMD_RST 1
`define AST_CMD_PRE 2
`define AST_CMD_ARM_IMM 3
`define AST_CMD_ARM_SIG 4
`define AST_CMD_SCAN_IMM 5
`define AST_CMD_SCAN_SIG 6
`define AST_CMD_TRG 7

// ----------------------------------------------------------------
// reset values and limits
// ----------------------------------------------------------------
`define AST_CNT_ONE 14'h0001
`define AST_CNT_INF 14'h0000
`define AST_MAX_COUNT 14'h270F
`define AST_RST_TIMER 30'h00000001
`define AST_RST_DELAY 30'h00000000
`define AST_MAX_MS 30'h3B9AC9FF

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define AST_CLK_NS 50
`define AST_MS_NS 1000000

`endif

// file: verilog/ast_pkg.sv
// types shared by the sequencer
package ast_pkg;
    typedef enum logic [2:0] {
        AST_SRC_IMM,
        AST_SRC_MAN,
        AST_SRC_BUS,
        AST_SRC_EXT,
        AST_SRC_LINE,
        AST_SRC_TIMER,
        AST_SRC_HOLD
    } ast_src_t;

    typedef enum logic [2:0] {
        AST_ST_IDLE,
        AST_ST_ARM,
        AST_ST_SCAN,
        AST_ST_DELAY,
        AST_ST_CHAN
    } ast_state_t;
endpackage : ast_pkg

// file: verilog/ast_sequencer.sv
// idle, arm and scan layer sequencer with apb register access
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none
`include "ast_defs.svh"

module ast_sequencer
#(
    parameter int MS_CYCLES = `AST_MS_NS / `AST_CLK_NS
)
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic BUS_TRIG,
    input wire logic STEP_KEY,
    input wire logic REMOTE,
    input wire logic EXT_TRIG,
    input wire logic LINE_TRIG_IN,
    input wire logic CHAN_DONE,
    output logic LINE_TRIG_OUT,
    output logic CHAN_READY_OUT,
    output logic CHAN_START,
    output logic ARMED
);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    localparam logic [15:0] MS_LAST = 16'(MS_CYCLES - 1);

    ast_pkg::ast_state_t state_reg;
    ast_pkg::ast_src_t arm_src_reg;
    ast_pkg::ast_src_t scan_src_reg;
    logic cont_reg;
    logic byp_reg;
    logic [13:0] arm_cnt_reg;
    logic [13:0] scan_cnt_reg;
    logic [29:0] timer_reg;
    logic [29:0] delay_reg;
    logic init_pend_reg;
    logic arm_skip_reg;
    logic scan_imm_reg;
    logic scan_sig_reg;
    logic [13:0] arm_done_reg;
    logic [13:0] scan_done_reg;
    logic arm_first_reg;
    logic scan_first_reg;
    logic tmr_first_reg;
    logic [15:0] tmr_pre_reg;
    logic [29:0] tmr_left_reg;
    logic [15:0] dly_pre_reg;
    logic [29:0] dly_left_reg;
    logic [31:0] rdata_reg;
    logic line_out_reg;
    logic rdy_out_reg;
    logic start_reg;
    logic wr;
    logic hit;
    logic [7:0] cmd;
    logic clr;
    logic man_ev;
    logic bus_ev;
    logic tmr_ev;
    logic [3:0] src_ev;
    logic idle_go;
    logic arm_go;
    logic scan_go;
    logic skip_dly;
    logic dly_end;
    logic chan_end;
    logic more_s;
    logic more_a;
    logic fire;
    ast_pkg::ast_src_t ret_src;

    // ----------------------------------------------------------------
    // functions
    // ----------------------------------------------------------------
    // event of a selected source; hold and unknown codes never fire
    // events come in as arguments so the continuous assigns see every change
    function automatic logic src_hit(ast_pkg::ast_src_t s, logic tmr, logic [3:0] ev);
        case (s)
            ast_pkg::AST_SRC_IMM: src_hit = 1'b1;
            ast_pkg::AST_SRC_MAN: src_hit = ev[0];
            ast_pkg::AST_SRC_BUS: src_hit = ev[1];
            ast_pkg::AST_SRC_EXT: src_hit = ev[2];
            ast_pkg::AST_SRC_LINE: src_hit = ev[3];
            ast_pkg::AST_SRC_TIMER: src_hit = tmr;
            default: src_hit = 1'b0;
        endcase
    endfunction : src_hit

    // bypass applies only to external and shared line sources
    function automatic logic byp_ok(ast_pkg::ast_src_t s, logic en);
        byp_ok = en && (s == ast_pkg::AST_SRC_EXT || s == ast_pkg::AST_SRC_LINE);
    endfunction : byp_ok

    // another pass wanted; zero limit means infinite
    function automatic logic more(logic [13:0] done, logic [13:0] lim);
        more = (lim == `AST_CNT_INF) || (done + 14'h0001 < lim);
    endfunction : more

    function automatic logic [13:0] clamp_cnt(logic [15:0] v);
        clamp_cnt = (v > 16'(`AST_MAX_COUNT)) ? `AST_MAX_COUNT : v[13:0];
    endfunction : clamp_cnt

    function automatic logic [29:0] clamp_ms(logic [29:0] v, logic [29:0] lo);
        if (v < lo)
        begin
            clamp_ms = lo;
        end
        else
        begin
            clamp_ms = (v > `AST_MAX_MS) ? `AST_MAX_MS : v;
        end
    endfunction : clamp_ms

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    // zero wait state slave; unmapped addresses answer with an error
    assign PREADY = 1'b1;
    assign wr = PSEL && PENABLE && PWRITE;
    assign hit = (PADDR <= `AST_OFF_PROG) && (PADDR[1:0] == 2'b00);
    assign PSLVERR = PSEL && PENABLE && !hit;
    assign cmd = (wr && PADDR == `AST_OFF_CMD) ? PWDATA[7:0] : 8'h00;
    assign clr = cmd[`AST_CMD_RST] || cmd[`AST_CMD_PRE];
    assign PRDATA = rdata_reg;

    // read data captured in the setup phase
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            rdata_reg <= 32'h00000000;
        end
        else if (PSEL && !PENABLE)
        begin
            if (PADDR == `AST_OFF_CTRL)
                rdata_reg <= {30'h0, byp_reg, cont_reg};
            else if (PADDR == `AST_OFF_ARM_SRC)
                rdata_reg <= {29'h0, arm_src_reg};
            else if (PADDR == `AST_OFF_SCAN_SRC)
                rdata_reg <= {29'h0, scan_src_reg};
            else if (PADDR == `AST_OFF_ARM_CNT)
                rdata_reg <= {18'h0, arm_cnt_reg};
            else if (PADDR == `AST_OFF_SCAN_CNT)
                rdata_reg <= {18'h0, scan_cnt_reg};
            else if (PADDR == `AST_OFF_TIMER)
                rdata_reg <= {2'h0, timer_reg};
            else if (PADDR == `AST_OFF_DELAY)
                rdata_reg <= {2'h0, delay_reg};
            else if (PADDR == `AST_OFF_STATUS)
                rdata_reg <= {28'h0, init_pend_reg, state_reg};
            else if (PADDR == `AST_OFF_PROG)
                rdata_reg <= {2'h0, arm_done_reg, 2'h0, scan_done_reg};
            else
                rdata_reg <= 32'h00000000;
        end
    end

    // ----------------------------------------------------------------
    // configuration registers
    // ----------------------------------------------------------------
    // reset and preset restore defaults, but only the reset input clears bypass; the commands differ only in scan count
    always_ff @(posedge CLK)
    begin
        if (RST || clr)
        begin
            cont_reg <= 1'b0;
            arm_src_reg <= ast_pkg::AST_SRC_IMM;
            scan_src_reg <= ast_pkg::AST_SRC_IMM;
            arm_cnt_reg <= `AST_CNT_ONE;
            scan_cnt_reg <= (!RST && cmd[`AST_CMD_PRE]) ? `AST_CNT_INF : `AST_CNT_ONE;
            timer_reg <= `AST_RST_TIMER;
            delay_reg <= `AST_RST_DELAY;
            byp_reg <= RST ? 1'b0 : byp_reg;
        end
        else if (wr)
        begin
            if (PADDR == `AST_OFF_CTRL)
            begin
                cont_reg <= PWDATA[`AST_CTRL_CONT];
                byp_reg <= PWDATA[`AST_CTRL_BYP];
            end
            else if (PADDR == `AST_OFF_ARM_SRC)
                arm_src_reg <= ast_pkg::ast_src_t'(PWDATA[2:0]);
            else if (PADDR == `AST_OFF_SCAN_SRC)
                scan_src_reg <= ast_pkg::ast_src_t'(PWDATA[2:0]);
            else if (PADDR == `AST_OFF_ARM_CNT)
                arm_cnt_reg <= clamp_cnt(PWDATA[15:0]);
            else if (PADDR == `AST_OFF_SCAN_CNT)
                scan_cnt_reg <= clamp_cnt(PWDATA[15:0]);
            else if (PADDR == `AST_OFF_TIMER)
                timer_reg <= clamp_ms(PWDATA[29:0], `AST_RST_TIMER);
            else if (PADDR == `AST_OFF_DELAY)
                delay_reg <= clamp_ms(PWDATA[29:0], `AST_RST_DELAY);
        end
    end

    // ----------------------------------------------------------------
    // layer events
    // ----------------------------------------------------------------
    // step key is locked out while the bus holds remote mode
    assign man_ev = STEP_KEY && !REMOTE;
    assign bus_ev = BUS_TRIG || cmd[`AST_CMD_TRG];
    assign src_ev = {LINE_TRIG_IN, EXT_TRIG, bus_ev, man_ev};
    assign tmr_ev = tmr_first_reg || (tmr_left_reg == 30'h0);
    assign idle_go = state_reg == ast_pkg::AST_ST_IDLE && (init_pend_reg || cont_reg);
    // arm has no timer source; a timer code there waits like hold
    assign arm_go = state_reg == ast_pkg::AST_ST_ARM && (arm_skip_reg
        || src_hit(arm_src_reg, 1'b0, src_ev)
        || (arm_first_reg && byp_ok(arm_src_reg, byp_reg)));
    assign scan_go = state_reg == ast_pkg::AST_ST_SCAN && (scan_imm_reg || scan_sig_reg
        || src_hit(scan_src_reg, tmr_ev, src_ev)
        || (scan_first_reg && byp_ok(scan_src_reg, byp_reg)));
    assign skip_dly = scan_imm_reg || delay_reg == 30'h0;
    assign dly_end = state_reg == ast_pkg::AST_ST_DELAY && dly_left_reg == 30'h0;
    assign chan_end = state_reg == ast_pkg::AST_ST_CHAN && CHAN_DONE;
    assign more_s = more(scan_done_reg, scan_cnt_reg);
    assign more_a = more(arm_done_reg, arm_cnt_reg);

    // ----------------------------------------------------------------
    // state machine
    // ----------------------------------------------------------------
    always_ff @(posedge CLK)
    begin
        if (RST || clr)
        begin
            state_reg <= ast_pkg::AST_ST_IDLE;
        end
        else
        begin
            case (state_reg)
                ast_pkg::AST_ST_IDLE:
                    if (idle_go)
                        state_reg <= ast_pkg::AST_ST_ARM;
                ast_pkg::AST_ST_ARM:
                    if (arm_go)
                        state_reg <= ast_pkg::AST_ST_SCAN;
                ast_pkg::AST_ST_SCAN:
                    if (scan_go)
                        state_reg <= skip_dly ? ast_pkg::AST_ST_CHAN : ast_pkg::AST_ST_DELAY;
                ast_pkg::AST_ST_DELAY:
                    if (dly_end)
                        state_reg <= ast_pkg::AST_ST_CHAN;
                ast_pkg::AST_ST_CHAN:
                    if (CHAN_DONE)
                    begin
                        if (more_s)
                            state_reg <= ast_pkg::AST_ST_SCAN;
                        else if (more_a)
                            state_reg <= ast_pkg::AST_ST_ARM;
                        else
                            state_reg <= ast_pkg::AST_ST_IDLE;
                    end
                default:
                    state_reg <= ast_pkg::AST_ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // pending one-shot commands
    // ----------------------------------------------------------------
    // a command in the consuming cycle survives: set wins over clear
    always_ff @(posedge CLK)
    begin
        if (RST || clr)
        begin
            init_pend_reg <= 1'b0;
            arm_skip_reg <= 1'b0;
            scan_imm_reg <= 1'b0;
            scan_sig_reg <= 1'b0;
        end
        else
        begin
            init_pend_reg <= cmd[`AST_CMD_INIT] || (init_pend_reg && !idle_go);
            arm_skip_reg <= cmd[`AST_CMD_ARM_IMM] || cmd[`AST_CMD_ARM_SIG]
                || (arm_skip_reg && !arm_go);
            scan_imm_reg <= cmd[`AST_CMD_SCAN_IMM] || (scan_imm_reg && !scan_go);
            scan_sig_reg <= cmd[`AST_CMD_SCAN_SIG] || (scan_sig_reg && !scan_go);
        end
    end

    // ----------------------------------------------------------------
    // pass counters and first-pass flags
    // ----------------------------------------------------------------
    always_ff @(posedge CLK)
    begin
        if (RST || clr)
        begin
            arm_done_reg <= 14'h0000;
            scan_done_reg <= 14'h0000;
            arm_first_reg <= 1'b1;
            scan_first_reg <= 1'b1;
            tmr_first_reg <= 1'b1;
        end
        else if (idle_go)
        begin
            arm_done_reg <= 14'h0000;
            arm_first_reg <= 1'b1;
        end
        else if (arm_go)
        begin
            arm_first_reg <= 1'b0;
            scan_done_reg <= 14'h0000;
            scan_first_reg <= 1'b1;
            tmr_first_reg <= 1'b1;
        end
        else if (scan_go)
        begin
            scan_first_reg <= 1'b0;
            tmr_first_reg <= 1'b0;
        end
        else if (chan_end)
        begin
            // infinite counts wrap harmlessly; the limit test ignores them
            if (more_s)
                scan_done_reg <= scan_done_reg + 14'h0001;
            else
                arm_done_reg <= arm_done_reg + 14'h0001;
        end
    end

    // ----------------------------------------------------------------
    // scan timer and scan delay
    // ----------------------------------------------------------------
    // the interval runs from each scan event, so waiting adds no drift
    always_ff @(posedge CLK)
    begin
        if (RST || clr)
        begin
            tmr_pre_reg <= 16'h0000;
            tmr_left_reg <= 30'h0;
        end
        else if (scan_go)
        begin
            tmr_pre_reg <= 16'h0000;
            tmr_left_reg <= timer_reg;
        end
        else if (tmr_left_reg != 30'h0)
        begin
            tmr_pre_reg <= (tmr_pre_reg == MS_LAST) ? 16'h0000 : tmr_pre_reg + 16'h0001;
            if (tmr_pre_reg == MS_LAST)
                tmr_left_reg <= tmr_left_reg - 30'h1;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (RST || clr)
        begin
            dly_pre_reg <= 16'h0000;
            dly_left_reg <= 30'h0;
        end
        else if (scan_go)
        begin
            dly_pre_reg <= 16'h0000;
            dly_left_reg <= delay_reg;
        end
        else if (dly_left_reg != 30'h0)
        begin
            dly_pre_reg <= (dly_pre_reg == MS_LAST) ? 16'h0000 : dly_pre_reg + 16'h0001;
            if (dly_pre_reg == MS_LAST)
                dly_left_reg <= dly_left_reg - 30'h1;
        end
    end

    // ----------------------------------------------------------------
    // output pulses
    // ----------------------------------------------------------------
    // pulse follows the source of the layer being re-entered
    assign ret_src = more_s ? scan_src_reg : arm_src_reg;
    assign fire = chan_end && byp_reg && (more_s || more_a);

    always_ff @(posedge CLK)
    begin
        if (RST || clr)
        begin
            line_out_reg <= 1'b0;
            rdy_out_reg <= 1'b0;
            start_reg <= 1'b0;
        end
        else
        begin
            line_out_reg <= fire && ret_src == ast_pkg::AST_SRC_LINE;
            rdy_out_reg <= fire && ret_src != ast_pkg::AST_SRC_LINE;
            start_reg <= (scan_go && skip_dly) || dly_end;
        end
    end

    assign LINE_TRIG_OUT = line_out_reg;
    assign CHAN_READY_OUT = rdy_out_reg;
    assign CHAN_START = start_reg;
    assign ARMED = state_reg != ast_pkg::AST_ST_IDLE;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    a_idle_stays: assert property (
        state_reg == ast_pkg::AST_ST_IDLE && !cont_reg && !init_pend_reg |=> !ARMED)
        else $error("left idle without initiate");
    a_cont_restart: assert property (
        state_reg == ast_pkg::AST_ST_IDLE && cont_reg && !clr |=> state_reg == ast_pkg::AST_ST_ARM)
        else $error("continuous initiation did not leave idle");
    a_cmd_to_idle: assert property (
        clr |=> state_reg == ast_pkg::AST_ST_IDLE && !CHAN_START)
        else $error("reset command did not force idle");
    a_arm_immediate: assert property (
        state_reg == ast_pkg::AST_ST_ARM && arm_src_reg == ast_pkg::AST_SRC_IMM && !clr
        |=> state_reg == ast_pkg::AST_ST_SCAN)
        else $error("immediate arm source waited");
    a_manual_remote: assert property (
        state_reg == ast_pkg::AST_ST_ARM && arm_src_reg == ast_pkg::AST_SRC_MAN && REMOTE
        && !arm_skip_reg && !arm_first_reg |=> state_reg == ast_pkg::AST_ST_ARM)
        else $error("step key taken in remote");
    a_hold_waits: assert property (
        state_reg == ast_pkg::AST_ST_SCAN && scan_src_reg == ast_pkg::AST_SRC_HOLD
        && !scan_imm_reg && !scan_sig_reg && !clr |=> state_reg == ast_pkg::AST_ST_SCAN)
        else $error("hold source left scan layer");
    a_no_pulse_acc: assert property (
        !byp_reg |=> !LINE_TRIG_OUT && !CHAN_READY_OUT)
        else $error("output pulse with bypass off");
    a_scan_pulse: assert property (
        chan_end && byp_reg && more_s && !clr |=> LINE_TRIG_OUT != CHAN_READY_OUT)
        else $error("no pulse on return to scan layer");
    a_imm_no_delay: assert property (
        scan_go && scan_imm_reg && !clr |=> CHAN_START ##1 !CHAN_START)
        else $error("scan immediate did not skip delay");
    a_delay_held: assert property (
        scan_go && !skip_dly && !clr |=> state_reg == ast_pkg::AST_ST_DELAY [*2])
        else $error("delay not applied");
    a_count_range: assert property (
        scan_cnt_reg <= `AST_MAX_COUNT && arm_cnt_reg <= `AST_MAX_COUNT)
        else $error("count above limit");
    a_last_to_idle: assert property (
        chan_end && !more_s && !more_a && !clr |=> state_reg == ast_pkg::AST_ST_IDLE)
        else $error("exhausted counts did not reach idle");

    c_delay_path: cover property (state_reg == ast_pkg::AST_ST_DELAY ##1 CHAN_START);
    c_rearm: cover property (chan_end && !more_s && more_a);
    c_line_pulse: cover property (LINE_TRIG_OUT);
    c_cont_loop: cover property (chan_end && !more_s && !more_a && cont_reg);

endmodule : ast_sequencer
`default_nettype wire

// file: verif/ast_partner.sv
// channel layer stand-in answering each channel start
`timescale 1ns/10ps
`default_nettype none
module ast_partner
(
    input wire logic clk,
    input wire logic chan_start,
    output logic chan_done
);
    logic [2:0] dly_reg;
    // ------------------------------------------------------------
    // done pulse
    // ------------------------------------------------------------
    // done four cycles after start, so the sequencer really waits
    always @(posedge clk)
    begin
        dly_reg <= {dly_reg[1:0], chan_start === 1'b1};
        chan_done <= dly_reg[2];
    end
    initial
    begin
        dly_reg = 3'h0;
        chan_done = 1'b0;
    end
endmodule : ast_partner
`default_nettype wire

// file: verif/tb_arm_scan_trigger_sequencer.sv
// self-checking bench for the arm and scan sequencer
`timescale 1ns/10ps
`default_nettype none
`include "ast_defs.svh"
module tb_arm_scan_trigger_sequencer;
    typedef struct {logic [2:0] a; logic [2:0] s; logic [3:0] t; logic rem; logic [7:0] c;
        logic go;} ast_row_t;
    logic clk, rst, psel, penable, pwrite, pready, pslverr, err, bus_t, key, remote;
    logic ext_t, line_t, chan_done, line_out, ready_out, chan_start, armed;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    int n_errors, checks, n_start, n_rdy, n_line, i, k, r, l;
    // trigger mask bits: 0 bus, 1 key, 2 external, 3 shared line
    ast_row_t rows [13] = '{'{3'h0, 3'h0, 4'h0, 1'b0, 8'h00, 1'b1},
        '{3'h0, 3'h1, 4'h2, 1'b0, 8'h00, 1'b1}, '{3'h0, 3'h1, 4'h2, 1'b1, 8'h00, 1'b0},
        '{3'h0, 3'h2, 4'h1, 1'b0, 8'h00, 1'b1}, '{3'h0, 3'h2, 4'h0, 1'b0, 8'h80, 1'b1},
        '{3'h0, 3'h3, 4'h4, 1'b0, 8'h00, 1'b1}, '{3'h0, 3'h4, 4'h8, 1'b0, 8'h00, 1'b1},
        '{3'h0, 3'h6, 4'hF, 1'b0, 8'h00, 1'b0}, '{3'h6, 3'h0, 4'hF, 1'b0, 8'h08, 1'b1},
        '{3'h0, 3'h6, 4'h0, 1'b0, 8'h40, 1'b1}, '{3'h3, 3'h0, 4'h4, 1'b0, 8'h00, 1'b1},
        '{3'h6, 3'h0, 4'hF, 1'b0, 8'h10, 1'b1}, '{3'h0, 3'h6, 4'h0, 1'b0, 8'h20, 1'b1}};

    ast_sequencer #(.MS_CYCLES(4)) i_ast_sequencer (.CLK(clk), .RST(rst), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .BUS_TRIG(bus_t), .STEP_KEY(key), .REMOTE(remote),
        .EXT_TRIG(ext_t), .LINE_TRIG_IN(line_t), .CHAN_DONE(chan_done),
        .LINE_TRIG_OUT(line_out), .CHAN_READY_OUT(ready_out), .CHAN_START(chan_start),
        .ARMED(armed));
    ast_partner i_ast_partner (.clk(clk), .chan_start(chan_start), .chan_done(chan_done));

    // ------------------------------------------------------------
    // clock, pulse counters and watchdog
    // ------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk)
    begin
        if (chan_start === 1'b1) n_start++;
        if (ready_out === 1'b1) n_rdy++;
        if (line_out === 1'b1) n_line++;
    end
    // whole run needs under a thousand cycles
    initial
    begin
        repeat (5000) @(posedge clk);
        n_errors++;
        complete_run();
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // one apb transfer; an extra edge after release keeps strobes apart
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic complete_run();
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : complete_run

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        {rst, psel, penable, pwrite, bus_t, key, remote, ext_t, line_t} = 9'h100;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        apb(1'b0, `AST_OFF_ARM_CNT, 32'h0);
        check("arm count", 32'h1, rd);
        apb(1'b0, `AST_OFF_SCAN_CNT, 32'h0);
        check("scan count", 32'h1, rd);
        apb(1'b0, `AST_OFF_DELAY, 32'h0);
        check("delay", 32'h0, rd);
        apb(1'b0, `AST_OFF_SCAN_SRC, 32'h0);
        check("scan source", 32'h0, rd);
        apb(1'b0, 8'h28, 32'h0);
        check("unmapped error", 32'h1, {31'h0, err});
        // each row: reset command, sources, initiate, one trigger, then the row's command if it has one
        for (i = 0; i < 13; i++)
        begin
            apb(1'b1, `AST_OFF_CMD, 32'h2);
            apb(1'b1, `AST_OFF_ARM_SRC, {29'h0, rows[i].a});
            apb(1'b1, `AST_OFF_SCAN_SRC, {29'h0, rows[i].s});
            apb(1'b1, `AST_OFF_CMD, 32'h1);
            k = n_start;
            repeat (4) @(posedge clk);
            remote <= rows[i].rem;
            {line_t, ext_t, key, bus_t} <= rows[i].t;
            @(posedge clk);
            {line_t, ext_t, key, bus_t} <= 4'h0;
            if (rows[i].c != 8'h00) apb(1'b1, `AST_OFF_CMD, {24'h0, rows[i].c});
            repeat (12) @(posedge clk);
            check("starts", {31'h0, rows[i].go}, 32'(n_start - k));
            check("armed", {31'h0, !rows[i].go}, {31'h0, armed});
            remote <= 1'b0;
            $display("row %0d done", i);
        end
        // bypass with two arms: one pulse on the return to the arm layer only
        apb(1'b1, `AST_OFF_CMD, 32'h2);
        apb(1'b1, `AST_OFF_CTRL, 32'h2);
        apb(1'b1, `AST_OFF_ARM_CNT, 32'h2);
        k = n_start;
        r = n_rdy;
        apb(1'b1, `AST_OFF_CMD, 32'h1);
        repeat (30) @(posedge clk);
        check("two arm starts", 32'h2, 32'(n_start - k));
        check("ready pulses", 32'h1, 32'(n_rdy - r));
        $display("bypass test done");
        // bypass with shared line scan source: first scan skips its wait, return pulses
        apb(1'b1, `AST_OFF_CMD, 32'h2);
        apb(1'b1, `AST_OFF_SCAN_SRC, 32'h4);
        apb(1'b1, `AST_OFF_SCAN_CNT, 32'h2);
        k = n_start;
        l = n_line;
        apb(1'b1, `AST_OFF_CMD, 32'h1);
        repeat (11) @(posedge clk);
        check("bypassed scan", 32'h1, 32'(n_start - k));
        check("line pulse", 32'h1, 32'(n_line - l));
        line_t <= 1'b1;
        @(posedge clk);
        line_t <= 1'b0;
        repeat (10) @(posedge clk);
        check("line scan", 32'h2, 32'(n_start - k));
        check("no end pulse", 32'h1, 32'(n_line - l));
        $display("shared line test done");
        // preset defaults
        apb(1'b1, `AST_OFF_CMD, 32'h4);
        apb(1'b0, `AST_OFF_SCAN_CNT, 32'h0);
        check("preset scan count", 32'h0, rd);
        apb(1'b0, `AST_OFF_ARM_CNT, 32'h0);
        check("preset arm count", 32'h1, rd);
        // continuous initiation keeps restarting until a reset command
        apb(1'b1, `AST_OFF_CMD, 32'h2);
        k = n_start;
        apb(1'b1, `AST_OFF_CTRL, 32'h1);
        repeat (30) @(posedge clk);
        check("restarting", 32'h1, {31'h0, (n_start - k) > 1});
        apb(1'b1, `AST_OFF_CMD, 32'h2);
        repeat (2) @(posedge clk);
        check("idle after reset", 32'h0, {31'h0, armed});
        $display("continuous test done");
        // timer source, 1 ms delay, three scans; scan immediate ends the third wait
        apb(1'b1, `AST_OFF_SCAN_SRC, 32'h5);
        apb(1'b1, `AST_OFF_SCAN_CNT, 32'h3);
        apb(1'b1, `AST_OFF_TIMER, 32'h5);
        apb(1'b1, `AST_OFF_DELAY, 32'h1);
        k = n_start;
        apb(1'b1, `AST_OFF_CMD, 32'h1);
        repeat (6) @(posedge clk);
        check("delayed start", 32'h0, 32'(n_start - k));
        repeat (9) @(posedge clk);
        check("first timer scan", 32'h1, 32'(n_start - k));
        repeat (20) @(posedge clk);
        check("timed scan", 32'h2, 32'(n_start - k));
        apb(1'b1, `AST_OFF_CMD, 32'h20);
        repeat (3) @(posedge clk);
        check("scan immediate", 32'h3, 32'(n_start - k));
        repeat (5) @(posedge clk);
        check("timer idle", 32'h0, {31'h0, armed});
        $display("timer test done");
        complete_run();
    end
endmodule : tb_arm_scan_trigger_sequencer
`default_nettype wire
